// File: design/gxr_pkg.sv
// constants, register map and types for the gigabit lane sync / rate match block
// assumes a single 50 MHz system clock and an APB register port
package gxr_pkg;

    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_FILL = 8'h08;

    localparam logic [1:0] CTRL_RST = 2'h1;
    localparam int CTRL_RM_EN = 0;
    localparam int CTRL_C2_EN = 1;

    // symbol values as {y[2:0], x[4:0]}
    localparam logic [7:0] SYM_K285 = 8'hBC;
    localparam logic [7:0] SYM_K307 = 8'hFE;
    localparam logic [7:0] SYM_D56 = 8'hC5;
    localparam logic [7:0] SYM_D162 = 8'h50;
    localparam logic [7:0] SYM_D215 = 8'hB5;
    localparam logic [7:0] SYM_D22 = 8'h42;
    localparam logic [5:0] K28_6B = 6'h0F;
    localparam logic [4:0] X_K28 = 5'h1C;

    // idle data groups as they leave the encoder after a comma
    localparam logic [9:0] CG_D56_RDN = 10'h296;
    localparam logic [9:0] CG_D162_RDP = 10'h245;

    localparam logic [1:0] TX_AUTO_COMMAS = 2'h3;
    localparam logic [1:0] SYNC_SETS = 2'h3;
    localparam logic [2:0] SYNC_ERRS = 3'h4;
    localparam logic [2:0] GOOD_RUN = 3'h4;

    localparam int PPM_TOL = 100;
    localparam int PPM_TOTAL = 2 * PPM_TOL;
    localparam int FRAME_MAX = 9600;
    localparam int RM_SLIP = (FRAME_MAX * PPM_TOTAL + 999999) / 1000000;
    localparam int RM_HYST = 2 * RM_SLIP;
    localparam int RM_W = 11;

    localparam int GMII_MHZ = 125;
    localparam int CLK_MHZ = 50;

    typedef enum logic [1:0] {SY_LOSS, SY_ACQ, SY_SYNC} gxr_sync_e;

endpackage : gxr_pkg

// File: design/gxr_rm_mem.sv
// storage of the rate match fifo, registered read data
// assumes the caller keeps pointers and never reads and writes out of range
`timescale 1ns/1ps
module gxr_rm_mem #(
    parameter int W = 11,
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic wr_en_i,
    input wire logic [AW-1:0] wr_addr_i,
    input wire logic [W-1:0] wr_data_i,
    input wire logic rd_en_i,
    input wire logic [AW-1:0] rd_addr_i,
    output logic [W-1:0] rd_data_o
);
    logic [W-1:0] mem_r [DEPTH];

    always_ff @(posedge clk_sys_i) begin
        if (wr_en_i) begin
            mem_r[wr_addr_i] <= wr_data_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_o <= '0;
        end else if (rd_en_i) begin
            rd_data_o <= mem_r[rd_addr_i];
        end
    end

endmodule : gxr_rm_mem

// File: design/gxr_top.sv
// lane transmit start-up and encoder, receive sync machine, rate match fifo
// assumes decoded receive groups from logic on the same clock, apb master
// Behaviour
// [RULE_01] after reset release send three commas before any user byte
// [RULE_02] fabric aligns its sync sequence so commas land on even boundaries
// [RULE_03] comma on odd boundary drops sync and that set is not counted; once synchronized the code only counts it as one error
// [RULE_04] fifo absorbs plus or minus 100 ppm between far and local clocks
// [RULE_05] no insertion or deletion until lane sync is high
// [RULE_06] only whole comma plus idle data pairs are inserted or deleted
// [RULE_07] as many idle pairs as needed are inserted or deleted
// [RULE_08] odd corrections round up to a whole pair
// [RULE_09] inserted and deleted flags stand with the affected idle symbols
// [RULE_10] optionally configuration comma pairs are also handled
// [RULE_11] sync declared after three consecutive valid sync sets
// [RULE_12] a sync set is a comma followed by odd count of data
// [RULE_13] per lane sync flag high while synchronized, low otherwise
// [RULE_14] sync lost on reset or after four errors without recovery
// [RULE_15] four good groups in a row remove one counted error
// [RULE_16] fabric side carries 8-bit data with enable and error controls
// [RULE_17] data after comma becomes idle code chosen by running disparity
// [RULE_18] encoder turns byte plus control flag into a 10-bit group
// [RULE_19] delete above mid fill, insert below, only at idle boundaries
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module gxr_top
    import gxr_pkg::*;
#(
    parameter int RM_DEPTH = 32
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_ctrl_i,
    input wire logic tx_en_i,
    input wire logic tx_er_i,
    output logic [9:0] tx_code_o,
    output logic tx_user_o,
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_ctrl_i,
    input wire logic rx_cgerr_i,
    output logic rx_sync_o,
    input wire logic rm_rd_en_i,
    output logic [7:0] rx_data_o,
    output logic rx_ctrl_o,
    output logic rx_err_o,
    output logic rx_dv_o,
    output logic rm_ins_o,
    output logic rm_del_o,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o
);
    localparam int AW = $clog2(RM_DEPTH);
    localparam logic [AW:0] RM_HI = (AW+1)'(RM_DEPTH / 2 + RM_HYST);
    localparam logic [AW:0] RM_LO = (AW+1)'(RM_DEPTH / 2 - RM_HYST);
    localparam logic [AW:0] RM_FULL = (AW+1)'(RM_DEPTH);
    localparam logic [AW-1:0] PTR_LAST = AW'(RM_DEPTH - 1);

    localparam logic [5:0] TBL6 [32] = '{
        6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
        6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
        6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
        6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
    localparam logic [3:0] TBL4 [8] = '{
        4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

    // returns {running disparity after, abcdei, fghj}; controls K28.1, K28.2, K28.5, K28.6, K23.7, K27.7, K29.7 and K30.7
    function automatic logic [10:0] gxr_enc(input logic [7:0] d, input logic k,
                                            input logic rd);
        logic [5:0] s;
        logic [3:0] f;
        logic r;
        logic a7;
        logic [4:0] x;
        x = d[4:0];
        s = (k && x == X_K28) ? K28_6B : TBL6[x];
        if (rd && (($countones(s) != 3) || x == 5'h07)) s = ~s;
        r = rd ^ ($countones(s) != 3);
        a7 = (d[7:5] == 3'h7) && (k || (!r && (x == 5'h11 || x == 5'h12 || x == 5'h14))
             || (r && (x == 5'h0B || x == 5'h0D || x == 5'h0E)));
        f = a7 ? 4'h7 : TBL4[d[7:5]];
        if ((k && x == X_K28) ? rd : (r && (($countones(f) != 2) || d[7:5] == 3'h3))) f = ~f;
        gxr_enc = {r ^ ($countones(f) != 2), s, f};
    endfunction : gxr_enc

    // transmit
    logic [1:0] tx_auto_r;
    logic tx_rd_r;
    logic tx_prev_k_r;
    logic tx_comma_rd_r;
    logic tx_odd_r;
    logic tx_k;
    logic [7:0] tx_d;
    logic tx_subst;
    logic [10:0] tx_enc;
    logic tx_is_comma;

    always_comb begin
        tx_k = 1'b1;
        tx_d = SYM_K285;
        if (tx_auto_r == TX_AUTO_COMMAS) begin
            if (tx_er_i) begin
                tx_d = SYM_K307;
            end else if (tx_en_i) begin // [RULE_16]
                tx_k = tx_ctrl_i;
                tx_d = tx_data_i;
            end else if (tx_odd_r) begin
                tx_k = 1'b0;
                tx_d = SYM_D162;
            end
        end
        tx_is_comma = tx_k && tx_d == SYM_K285;
        tx_subst = tx_prev_k_r && !tx_k && tx_d != SYM_D215 && tx_d != SYM_D22;
        if (tx_subst) begin
            tx_d = tx_comma_rd_r ? SYM_D56 : SYM_D162; // [RULE_17]
        end
        tx_enc = gxr_enc(tx_d, tx_k, tx_rd_r); // [RULE_18]
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_auto_r <= 2'h0;
            tx_user_o <= 1'b0;
        end else begin
            if (tx_auto_r != TX_AUTO_COMMAS) begin
                tx_auto_r <= tx_auto_r + 2'h1; // [RULE_01]
            end
            tx_user_o <= tx_auto_r == TX_AUTO_COMMAS;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_code_o <= 10'h000;
            tx_rd_r <= 1'b0;
            tx_prev_k_r <= 1'b0;
            tx_comma_rd_r <= 1'b0;
            tx_odd_r <= 1'b0;
        end else begin
            tx_code_o <= tx_enc[9:0];
            tx_rd_r <= tx_enc[10];
            tx_prev_k_r <= tx_is_comma;
            tx_odd_r <= tx_is_comma ? 1'b1 : ~tx_odd_r;
            if (tx_is_comma) begin
                tx_comma_rd_r <= tx_rd_r;
            end
        end
    end

    // receive sync machine
    gxr_sync_e sy_st_r;
    logic sy_odd_r;
    logic sy_need_d_r;
    logic [1:0] sy_sets_r;
    logic [2:0] sy_err_r;
    logic [2:0] sy_good_r;
    logic rx_comma;
    logic sy_bad;

    assign rx_comma = rx_ctrl_i && rx_data_i == SYM_K285;
    assign sy_bad = rx_cgerr_i || (rx_comma && sy_odd_r); // [RULE_12]

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sy_st_r <= SY_LOSS; // [RULE_14]
            rx_sync_o <= 1'b0;
            sy_odd_r <= 1'b0;
            sy_need_d_r <= 1'b0;
            sy_sets_r <= 2'h0;
            sy_err_r <= 3'h0;
            sy_good_r <= 3'h0;
        end else if (rx_valid_i) begin
            sy_odd_r <= rx_comma ? 1'b1 : ~sy_odd_r;
            case (sy_st_r)
                SY_LOSS: begin
                    if (rx_comma) begin
                        sy_st_r <= SY_ACQ;
                        sy_need_d_r <= 1'b1;
                        sy_sets_r <= 2'h0;
                    end
                end
                SY_ACQ: begin
                    if (sy_bad) begin
                        sy_st_r <= SY_LOSS; // [RULE_03]
                    end else if (rx_comma) begin
                        sy_need_d_r <= 1'b1;
                    end else if (sy_need_d_r) begin
                        sy_need_d_r <= 1'b0;
                        sy_sets_r <= sy_sets_r + 2'h1;
                        if (sy_sets_r + 2'h1 == SYNC_SETS) begin // [RULE_11]
                            sy_st_r <= SY_SYNC;
                            rx_sync_o <= 1'b1; // [RULE_13]
                            sy_err_r <= 3'h0;
                            sy_good_r <= 3'h0;
                        end
                    end
                end
                SY_SYNC: begin
                    if (sy_bad) begin
                        sy_good_r <= 3'h0;
                        sy_err_r <= sy_err_r + 3'h1;
                        if (sy_err_r + 3'h1 == SYNC_ERRS) begin // [RULE_14]
                            sy_st_r <= SY_LOSS;
                            rx_sync_o <= 1'b0; // [RULE_13]
                        end
                    end else if (sy_good_r + 3'h1 == GOOD_RUN) begin
                        sy_good_r <= 3'h0;
                        if (sy_err_r != 3'h0) begin
                            sy_err_r <= sy_err_r - 3'h1; // [RULE_15]
                        end
                    end else begin
                        sy_good_r <= sy_good_r + 3'h1;
                    end
                end
                default: begin
                    sy_st_r <= SY_LOSS;
                    rx_sync_o <= 1'b0;
                end
            endcase
        end
    end

    // rate match, write side: one group of look-behind so a pair can vanish whole
    logic [1:0] ctrl_r;
    logic [3:0] stat_r;
    logic [AW:0] rm_fill_r;
    logic [AW-1:0] rm_wp_r;
    logic [AW-1:0] rm_rp_r;
    logic [9:0] rm_s1_r;
    logic rm_s1_v_r;
    logic rm_s1_kill_r;
    logic [1:0] rm_del_pend_r;
    logic [RM_W-1:0] rm_q;
    logic rm_full;
    logic rm_empty;
    logic rx_deletable;
    logic del_go;
    logic wr_req;
    logic wr_go;

    assign rm_full = rm_fill_r == RM_FULL; // [RULE_04]
    assign rm_empty = rm_fill_r == '0;
    assign rx_deletable = !rx_ctrl_i && !rx_cgerr_i && (rx_data_i == SYM_D162
                          || (ctrl_r[CTRL_C2_EN] && rx_data_i == SYM_D22)); // [RULE_10]
    assign del_go = rx_valid_i && rm_s1_v_r && !rm_s1_kill_r && rx_deletable
                    && rm_s1_r == {2'b01, SYM_K285} && rx_sync_o // [RULE_05]
                    && ctrl_r[CTRL_RM_EN] && rm_fill_r >= RM_HI; // [RULE_19]
    assign wr_req = rx_valid_i && rm_s1_v_r && !rm_s1_kill_r && !del_go;
    assign wr_go = wr_req && !rm_full;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rm_s1_r <= 10'h000;
            rm_s1_v_r <= 1'b0;
            rm_s1_kill_r <= 1'b0;
            rm_del_pend_r <= 2'h0;
            rm_wp_r <= '0;
        end else begin
            if (rx_valid_i) begin
                rm_s1_r <= {rx_cgerr_i, rx_ctrl_i, rx_data_i};
                rm_s1_v_r <= 1'b1;
                rm_s1_kill_r <= del_go; // [RULE_06]
            end
            if (del_go) begin
                rm_del_pend_r <= 2'h2; // [RULE_09]
            end else if (wr_go && rm_del_pend_r != 2'h0) begin
                rm_del_pend_r <= rm_del_pend_r - 2'h1;
            end
            if (wr_go) begin
                rm_wp_r <= (rm_wp_r == PTR_LAST) ? '0 : rm_wp_r + 1'b1;
            end
        end
    end

    // read side: pairs are repeated right after an idle pair leaves the fifo
    logic rd_pend_r;
    logic [1:0] ins_cnt_r;
    logic last_k_r;
    logic ins_go;
    logic rd_go;
    logic ins_out;
    logic udr_ev;

    assign ins_go = rd_pend_r && rm_q[9:0] == {2'b00, SYM_D162} && last_k_r && rx_sync_o
                    && ctrl_r[CTRL_RM_EN] && rm_fill_r <= RM_LO && ins_cnt_r == 2'h0; // [RULE_19]
    assign rd_go = rm_rd_en_i && ins_cnt_r == 2'h0 && !ins_go && !rm_empty;
    assign ins_out = rm_rd_en_i && ins_cnt_r != 2'h0;
    assign udr_ev = rm_rd_en_i && ins_cnt_r == 2'h0 && !ins_go && rm_empty;

    gxr_rm_mem #(
        .W(RM_W),
        .DEPTH(RM_DEPTH),
        .AW(AW)
    ) u_mem (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .wr_en_i(wr_go),
        .wr_addr_i(rm_wp_r),
        .wr_data_i({rm_del_pend_r != 2'h0, rm_s1_r}),
        .rd_en_i(rd_go),
        .rd_addr_i(rm_rp_r),
        .rd_data_o(rm_q)
    );

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rm_fill_r <= '0;
            rm_rp_r <= '0;
        end else begin
            case ({wr_go, rd_go})
                2'b10: rm_fill_r <= rm_fill_r + 1'b1;
                2'b01: rm_fill_r <= rm_fill_r - 1'b1;
                default: rm_fill_r <= rm_fill_r;
            endcase
            if (rd_go) begin
                rm_rp_r <= (rm_rp_r == PTR_LAST) ? '0 : rm_rp_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_pend_r <= 1'b0;
            ins_cnt_r <= 2'h0;
            last_k_r <= 1'b0;
            rx_data_o <= 8'h00;
            rx_ctrl_o <= 1'b0;
            rx_err_o <= 1'b0;
            rx_dv_o <= 1'b0;
            rm_ins_o <= 1'b0;
            rm_del_o <= 1'b0;
        end else begin
            rd_pend_r <= rd_go;
            rx_dv_o <= rd_pend_r || ins_out;
            if (ins_go) begin
                ins_cnt_r <= 2'h2; // [RULE_07]
            end else if (ins_out) begin
                ins_cnt_r <= ins_cnt_r - 2'h1;
            end
            if (rd_pend_r) begin
                {rm_del_o, rx_err_o, rx_ctrl_o, rx_data_o} <= rm_q;
                rm_ins_o <= 1'b0;
                last_k_r <= rm_q[9:0] == {2'b01, SYM_K285};
            end else if (ins_out) begin
                rx_data_o <= (ins_cnt_r == 2'h2) ? SYM_K285 : SYM_D162; // [RULE_08]
                rx_ctrl_o <= ins_cnt_r == 2'h2;
                rx_err_o <= 1'b0;
                rm_del_o <= 1'b0;
                rm_ins_o <= 1'b1; // [RULE_09]
                last_k_r <= ins_cnt_r == 2'h2;
            end
        end
    end

    // apb slave, one wait-free access phase after each setup
    logic apb_setup;
    logic apb_wr;
    logic apb_hit;
    logic stat_clr;
    logic [3:0] stat_set;

    assign apb_setup = psel_i && !penable_i;
    assign apb_wr = psel_i && penable_i && pready_o && pwrite_i;
    assign apb_hit = paddr_i == OFS_CTRL || paddr_i == OFS_STAT || paddr_i == OFS_FILL;
    assign stat_clr = apb_wr && paddr_i == OFS_STAT;
    assign stat_set = {del_go, ins_go, udr_ev, wr_req && rm_full};

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else begin
            pready_o <= apb_setup;
            pslverr_o <= apb_setup && !apb_hit;
            prdata_o <= 32'h0000_0000;
            if (apb_setup && !pwrite_i) begin
                case (paddr_i)
                    OFS_CTRL: prdata_o <= 32'(ctrl_r);
                    OFS_STAT: prdata_o <= {27'h0, stat_r, rx_sync_o};
                    OFS_FILL: prdata_o <= 32'(rm_fill_r);
                    default: prdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_r <= CTRL_RST;
        end else if (apb_wr && paddr_i == OFS_CTRL) begin
            ctrl_r <= pwdata_i[1:0];
        end
    end

    // new events beat a write-one clear in the same cycle
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stat_r <= 4'h0;
        end else begin
            stat_r <= (stat_r & ~(stat_clr ? pwdata_i[4:1] : 4'h0)) | stat_set;
        end
    end

    property p_auto_commas;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        tx_auto_r != TX_AUTO_COMMAS |=> tx_code_o[9:4] == K28_6B || tx_code_o[9:4] == ~K28_6B;
    endproperty
    a_auto_commas: assert property (p_auto_commas) else $error("auto comma missing"); // [RULE_01]

    property p_idle_subst;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        tx_subst |=> tx_code_o == ($past(tx_comma_rd_r) ? CG_D56_RDN : CG_D162_RDP);
    endproperty
    a_idle_subst: assert property (p_idle_subst) else $error("wrong idle code"); // [RULE_17]

    property p_odd_loss;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        rx_valid_i && rx_comma && sy_odd_r && sy_st_r != SY_LOSS
        |=> sy_st_r == SY_LOSS || (sy_st_r == SY_SYNC && sy_err_r != 3'h0);
    endproperty
    a_odd_loss: assert property (p_odd_loss) else $error("odd comma ignored"); // [RULE_03]

    property p_sync_rise;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        $rose(rx_sync_o) |-> $past(sy_sets_r) == 2'h2 && $past(sy_st_r) == SY_ACQ;
    endproperty
    a_sync_rise: assert property (p_sync_rise) else $error("sync too early"); // [RULE_11]

    property p_err_loss;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        sy_st_r == SY_SYNC && rx_valid_i && sy_bad && sy_err_r == 3'h3 |=> !rx_sync_o;
    endproperty
    a_err_loss: assert property (p_err_loss) else $error("sync kept after errors"); // [RULE_14]

    property p_no_rm_unsync;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        !rx_sync_o |=> !$rose(stat_r[3]) && !$rose(stat_r[2]);
    endproperty
    a_no_rm_unsync: assert property (p_no_rm_unsync) else $error("rate match unsynced"); // [RULE_05]

    property p_ins_pair;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        ins_out && ins_cnt_r == 2'h2
        |=> rm_ins_o && rx_ctrl_o && rx_data_o == SYM_K285 && rx_dv_o;
    endproperty
    a_ins_pair: assert property (p_ins_pair) else $error("insert not a pair"); // [RULE_06]

    property p_del_tag;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        del_go |=> rm_s1_kill_r && rm_del_pend_r == 2'h2;
    endproperty
    a_del_tag: assert property (p_del_tag) else $error("delete not marked"); // [RULE_09]

    property p_fill_bound;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        rm_fill_r <= RM_FULL && !(wr_go && rm_full);
    endproperty
    a_fill_bound: assert property (p_fill_bound) else $error("fifo overrun"); // [RULE_07]

endmodule : gxr_top

// File: test/gxr_link_model.sv
// far-end lane partner: hands decoded receive groups to the block
// assumes callers start just after a rising edge of the block clock
`timescale 1ns/1ps
module gxr_link_model
    import gxr_pkg::*;
(
    input wire logic clk_i,
    output logic valid_o,
    output logic [7:0] data_o,
    output logic ctrl_o,
    output logic cgerr_o
);
    initial begin
        valid_o = 1'b0;
        data_o = 8'h00;
        ctrl_o = 1'b0;
        cgerr_o = 1'b0;
    end
    // gap cycle shows inverted lines so a stale group never looks held
    task put(input logic k, input logic [7:0] d, input logic e);
        @(posedge clk_i);
        valid_o <= 1'b1;
        data_o <= d;
        ctrl_o <= k;
        cgerr_o <= e;
        @(posedge clk_i);
        valid_o <= 1'b0;
        data_o <= ~d;
        ctrl_o <= ~k;
        cgerr_o <= ~e;
    endtask : put
    // comma always on an even boundary
    task pair();
        put(1'b1, SYM_K285, 1'b0);
        put(1'b0, SYM_D162, 1'b0);
    endtask : pair
endmodule : gxr_link_model

// File: test/gxr_top_test.sv
// self-checking bench for the lane sync and rate match block
// assumes gxr_link_model as far end; bench acts as apb master and mac
`timescale 1ns/1ps
module gxr_top_test;
    import gxr_pkg::*;
    localparam int DEPTH = 16;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic rv, rk, re, rm_rd = 1'b0, tx_user, rx_sync, rx_dv, rm_ins;
    logic tx_en = 1'b0, rq_k, rq_e, rm_del;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, pslverr, err;
    logic [7:0] rd8, rq, paddr = 8'h00;
    logic [9:0] tx_code;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    int mismatches = 0;
    int checks = 0;
    int ins_n = 0;
    int del_n = 0;
    always #10 clk = ~clk;
    gxr_link_model u_gxr_link_model (.clk_i(clk), .valid_o(rv), .data_o(rd8), .ctrl_o(rk),
        .cgerr_o(re));
    gxr_top #(.RM_DEPTH(DEPTH)) u_gxr_top (.clk_sys_i(clk), .rst_n_i(rst_n),
        .tx_data_i(8'h00), .tx_ctrl_i(1'b0), .tx_en_i(tx_en), .tx_er_i(1'b0),
        .tx_code_o(tx_code), .tx_user_o(tx_user), .rx_valid_i(rv), .rx_data_i(rd8),
        .rx_ctrl_i(rk), .rx_cgerr_i(re), .rx_sync_o(rx_sync), .rm_rd_en_i(rm_rd),
        .rx_data_o(rq), .rx_ctrl_o(rq_k), .rx_err_o(rq_e), .rx_dv_o(rx_dv), .rm_ins_o(rm_ins),
        .rm_del_o(rm_del), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task wrap_up();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
    endtask : do_reset
    task rd_sym();
        @(posedge clk);
        rm_rd <= 1'b1;
        @(posedge clk);
        rm_rd <= 1'b0;
    endtask : rd_sym
    // inserted symbols must come as comma then idle data
    always @(posedge clk) begin
        if (rx_dv === 1'b1 && rm_ins === 1'b1) begin
            chk({22'h0, rq_e, rq_k, rq}, ins_n[0] ? 32'(SYM_D162) : {24'h1, SYM_K285});
            ins_n++;
        end
        if (rx_dv === 1'b1 && rm_del === 1'b1) del_n++;
    end
    task t_tx_start();
        logic [9:0] k_exp[3];
        k_exp = '{10'h0FA, 10'h305, 10'h0FA};
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            @(negedge clk);
            chk(32'(tx_code), 32'(k_exp[i]));
            if (i < 2) chk(32'(tx_user), 0);
        end
        @(posedge clk);
        @(negedge clk);
        chk(32'(tx_code), 32'(CG_D162_RDP));
        chk(32'(tx_user), 1);
    endtask : t_tx_start
    // user byte right after a comma turns idle, the next one goes out as d0.0
    task t_tx_user();
        do @(negedge clk); while (tx_code !== CG_D162_RDP);
        @(posedge clk);
        tx_en <= 1'b1;
        repeat (2) @(posedge clk);
        tx_en <= 1'b0;
        @(negedge clk);
        chk(32'(tx_code), 32'h274);
    endtask : t_tx_user
    task t_presync();
        repeat (10) begin
            u_gxr_link_model.pair();
            u_gxr_link_model.put(1'b1, SYM_K285, 1'b0);
            u_gxr_link_model.put(1'b1, SYM_K285, 1'b0);
        end
        @(negedge clk);
        chk(32'(rx_sync), 0);
        apb(1'b0, OFS_STAT, 32'h0);
        chk(32'(rd[4]), 0);
        chk(32'(rd[1]), 1);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, OFS_CTRL, 32'h3);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rd, 32'h3);
        apb(1'b0, 8'h0C, 32'h0);
        chk({rd[30:0], err}, 32'h1);
    endtask : t_presync
    task t_odd_comma();
        do_reset();
        u_gxr_link_model.pair();
        u_gxr_link_model.put(1'b1, SYM_K285, 1'b0);
        u_gxr_link_model.put(1'b1, SYM_K285, 1'b0);
        repeat (2) u_gxr_link_model.pair();
        @(negedge clk);
        chk(32'(rx_sync), 0);
        u_gxr_link_model.pair();
        @(negedge clk);
        chk(32'(rx_sync), 1);
    endtask : t_odd_comma
    task t_errors();
        repeat (3) u_gxr_link_model.put(1'b0, 8'h00, 1'b1);
        repeat (4) u_gxr_link_model.put(1'b0, 8'h00, 1'b0);
        u_gxr_link_model.put(1'b0, 8'h00, 1'b1);
        @(negedge clk);
        chk(32'(rx_sync), 1);
        u_gxr_link_model.put(1'b0, 8'h00, 1'b1);
        @(negedge clk);
        chk(32'(rx_sync), 0);
    endtask : t_errors
    task t_rate_match();
        do_reset();
        repeat (15) u_gxr_link_model.pair();
        apb(1'b0, OFS_STAT, 32'h0);
        chk({rd[1], rd[4]}, 32'h1);
        apb(1'b0, OFS_FILL, 32'h0);
        chk(rd, 32'(DEPTH / 2 + RM_HYST));
        // a non-idle byte after the deleted pairs is written tagged, together with the comma ahead of it
        u_gxr_link_model.put(1'b1, SYM_K285, 1'b0);
        u_gxr_link_model.put(1'b0, 8'h00, 1'b0);
        u_gxr_link_model.put(1'b1, SYM_K285, 1'b0);
        repeat (24) rd_sym();
        apb(1'b0, OFS_STAT, 32'h0);
        chk(32'(rd[3:2]), 32'h3);
        chk(32'(ins_n > 0 && ins_n % 2 == 0), 1);
        chk(del_n, 2);
        apb(1'b1, OFS_STAT, 32'h1E);
        apb(1'b0, OFS_STAT, 32'h0);
        chk(32'(rd[4:0]), 32'h1);
    endtask : t_rate_match
    initial begin
        do_reset();
        t_tx_start();
        t_tx_user();
        t_presync();
        t_odd_comma();
        t_errors();
        t_rate_match();
        wrap_up();
    end
    // a few hundred cycles expected; cut off far beyond that
    initial begin
        #1000000;
        mismatches++;
        wrap_up();
    end
endmodule : gxr_top_test
